// ==== verilog/sdc_defines.svh ====
// Constants of the diagnosis serial slave: frame layout, codes, reset values.
// Assumes it is included by bare name from the design files.
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

`define SDC_FRAME_W       8
`define SDC_FRAME_MSB     7
`define SDC_WR_BIT        7
`define SDC_ADDR_HI       6
`define SDC_ADDR_LO       4
`define SDC_ADDR_DIAG     3'h7
`define SDC_BYP_BIT       3
`define SDC_MUX_HI        2
`define SDC_MUX_LO        0
`define SDC_MUX_RST       3'h6
`define SDC_MUX_LAST_CH   3'h4
`define SDC_MUX_OFF       3'h6
`define SDC_MUX_STBY      3'h7
`define SDC_CNT_W         3
`define SDC_CNT_ZERO      3'h0
`define SDC_CNT_ONE       3'h1
`define SDC_CH_N          5
`define SDC_RESP_RST      8'h00
`define SDC_SYNC_W        5
`define SDC_LINK_SYNC_RST 5'h10

`endif

// ==== verilog/sdc_pkg.sv ====
// Types shared by the diagnosis serial slave.
// Assumes sdc_defines.svh holds the numeric constants.
package sdc_pkg;

  typedef enum logic [1:0] {
    SDC_ST_IDLE   = 2'b00,
    SDC_ST_ACTIVE = 2'b01,
    SDC_ST_DECODE = 2'b10
  } sdc_state_t;

endpackage : sdc_pkg

// ==== verilog/sdc_sync.sv ====
// Two-flop level synchroniser for a vector of independent slow levels.
// Assumes each bit changes far slower than the sampling clock.
`timescale 1ns/1ps
module sdc_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock, reset, enable
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST;
      q_o    <= RST;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : sdc_sync

// ==== verilog/sdc_spi_diag_slave.sv ====
// Serial slave for the diagnosis control register and diagnosis response.
// Assumes the serial clock idles low and stands still while select is high;
// status inputs other than CHANNEL_ON_I come from outside the CLK_I domain.
`timescale 1ns/1ps
`include "sdc_defines.svh"

// Functional notes
// - Falling select starts an access and clears the bit count.
// - Input sampled on falling serial clock, output advanced on rising edge.
// - Frames travel most significant bit first in both directions.
// - Count clocks modulo eight; decode only on a nonzero multiple of eight.
// - Bad bit count sets the frame error flag and drops the command.
// - Valid end of access copies the frame into the addressed register.
// - Select high: ignore clock and input, serial output undriven.
// - First falling serial clock loads the pending response into the shift register.
// - Before first rising clock output shows frame error OR serial input.
// - One eight-bit shift register; displaced bits pass out for chaining.
// - Bit 7 write flag, bits 6..4 address, all ones selects diag_control.
// - Channel on: codes 000..100 route that channel's sense; 101, 110 idle.
// - Channel off: every code leaves the sense output undriven.
// - Code 111 means stand-by with the sense output undriven.
// - Bit 3 reads the bypass monitor; invalid in stand-by; written as 0.
// - Response: frame error first, then 0, status, don't care, faults.
// - Channel fault flag reads 1 after a failure on that channel.
// - Code 110 is the sense-disabled setting with the sense path off.
module sdc_spi_diag_slave
  import sdc_pkg::*;
#(
  parameter int CH_N = `SDC_CH_N
) (
  // System clock, enable and reset
  input  wire logic            CLK_I,
  input  wire logic            CE_I,
  input  wire logic            SYS_RST_I,
  // Serial link
  input  wire logic            SCLK_I,
  input  wire logic            CS_N_I,
  input  wire logic            SI_I,
  output logic                 SO_O,
  output logic                 SO_OE_N_O,
  // Power stage status
  input  wire logic [CH_N-1:0] CHANNEL_ON_I,
  input  wire logic [CH_N-1:0] CHANNEL_FAULT_I,
  input  wire logic            AUX_STATUS_I,
  input  wire logic            BYPASS_MONITOR_I,
  // Sense path control
  output logic                 SENSE_EN_O,
  output logic [2:0]           SENSE_SELECT_O,
  output logic                 STANDBY_O,
  // Access status
  output logic                 FRAME_ERROR_O
);

  // ---------------------------------------------------------------
  // Link domain, clocked by the serial clock
  // ---------------------------------------------------------------
  logic [`SDC_FRAME_MSB:0] link_sr_q;
  logic                    link_started_q;
  logic                    link_rose_q;
  logic                    link_tx_q;
  logic                    link_tgl_q;

  // System-side values the link reads while they are held still
  logic [`SDC_FRAME_MSB:0] resp_q;

  // Cleared while select is high so each access begins afresh
  always_ff @(negedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      link_started_q <= 1'b0;
    end else begin
      link_started_q <= 1'b1;
    end
  end

  // First falling edge merges the response with the first input bit
  always_ff @(negedge SCLK_I) begin
    if (!CS_N_I) begin
      if (!link_started_q) begin
        link_sr_q <= {resp_q[`SDC_FRAME_MSB-1:0], SI_I};
      end else begin
        link_sr_q <= {link_sr_q[`SDC_FRAME_MSB-1:0], SI_I};
      end
    end
  end

  // Toggles once per received bit; the system side counts the changes
  always_ff @(negedge SCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      link_tgl_q <= 1'b0;
    end else if (!CS_N_I) begin
      link_tgl_q <= ~link_tgl_q;
    end
  end

  always_ff @(posedge SCLK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      link_rose_q <= 1'b0;
    end else begin
      link_rose_q <= 1'b1;
    end
  end

  // Output bit: response MSB at the first rising edge, then shifted bits
  // From the ninth rising edge on, SI comes back out eight clocks later,
  // which is what lets frames flow along a chain
  always_ff @(posedge SCLK_I) begin
    if (!CS_N_I) begin
      if (!link_started_q) begin
        link_tx_q <= resp_q[`SDC_FRAME_MSB];
      end else begin
        link_tx_q <= link_sr_q[`SDC_FRAME_MSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // System domain
  // ---------------------------------------------------------------
  logic                  cs_n_s;
  logic                  si_s;
  logic                  rose_s;
  logic                  tx_s;
  logic                  tgl_s;
  logic [`SDC_SYNC_W-1:0] link_sync;

  // Select resets to its idle high level: a low value here would look like
  // a falling select and end in a false frame error after every reset
  sdc_sync #(
    .W   (`SDC_SYNC_W),
    .RST (`SDC_LINK_SYNC_RST)
  ) u_link_sync (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .ce_i  (CE_I),
    .d_i   ({CS_N_I, SI_I, link_rose_q, link_tx_q, link_tgl_q}),
    .q_o   (link_sync)
  );

  assign {cs_n_s, si_s, rose_s, tx_s, tgl_s} = link_sync;

  logic [CH_N-1:0] fault_s;
  logic            aux_s;
  logic            byp_s;
  logic [CH_N+1:0] stat_sync;

  // Status levels are slow; each bit is synchronised on its own
  sdc_sync #(
    .W   (CH_N + 2),
    .RST ('0)
  ) u_stat_sync (
    .clk_i (CLK_I),
    .rst_i (SYS_RST_I),
    .ce_i  (CE_I),
    .d_i   ({CHANNEL_FAULT_I, AUX_STATUS_I, BYPASS_MONITOR_I}),
    .q_o   (stat_sync)
  );

  assign {fault_s, aux_s, byp_s} = stat_sync;

  sdc_state_t              state_q;
  logic                    tgl_seen_q;
  logic [`SDC_CNT_W-1:0]   bit_cnt_q;
  logic                    any_clk_q;
  logic [`SDC_FRAME_MSB:0] frame_q;
  logic                    ter_q;
  logic                    rd_pend_q;
  logic [2:0]              mux_q;

  logic                    bit_evt;
  logic                    frame_ok;
  logic                    frame_wr;
  logic                    frame_diag;

  assign bit_evt    = (tgl_s != tgl_seen_q);
  // nonzero whole multiple of eight clocks
  assign frame_ok   = any_clk_q && (bit_cnt_q == `SDC_CNT_ZERO);
  assign frame_wr   = frame_q[`SDC_WR_BIT];
  assign frame_diag =
    (frame_q[`SDC_ADDR_HI:`SDC_ADDR_LO] == `SDC_ADDR_DIAG);

  // Access sequencing follows the synchronised select
  // Select pulses shorter than two clocks could slip past unseen; the
  // link's lead, lag and gap times keep every pulse far longer
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_q <= SDC_ST_IDLE;
    end else if (CE_I) begin
      case (state_q)
        SDC_ST_IDLE: begin
          if (!cs_n_s) begin
            state_q <= SDC_ST_ACTIVE;
          end
        end
        SDC_ST_ACTIVE: begin
          if (cs_n_s) begin
            state_q <= SDC_ST_DECODE;
          end
        end
        SDC_ST_DECODE: begin
          state_q <= SDC_ST_IDLE;
        end
        default: begin
          state_q <= SDC_ST_IDLE;
        end
      endcase
    end
  end

  // Bit counting and frame capture. The shift register is read across
  // domains only once its toggle has passed the synchroniser; by then it
  // has stood still for at least two system clocks.
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      tgl_seen_q <= 1'b0;
      bit_cnt_q  <= `SDC_CNT_ZERO;
      any_clk_q  <= 1'b0;
      frame_q    <= `SDC_RESP_RST;
    end else if (CE_I) begin
      tgl_seen_q <= tgl_s;
      if (state_q == SDC_ST_IDLE && !cs_n_s) begin
        bit_cnt_q <= `SDC_CNT_ZERO;
        any_clk_q <= 1'b0;
      end else if (state_q == SDC_ST_ACTIVE && bit_evt) begin
        bit_cnt_q <= bit_cnt_q + `SDC_CNT_ONE;
        any_clk_q <= 1'b1;
        frame_q   <= link_sr_q;
      end
    end
  end

  // Frame error flag: set by a bad count, cleared by a good access
  // A readback request never survives a bad access: its start cleared it
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ter_q <= 1'b0;
    end else if (CE_I && state_q == SDC_ST_DECODE) begin
      ter_q <= ~frame_ok;
    end
  end

  // Control register update only on a valid access
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      mux_q <= `SDC_MUX_RST;
    end else if (CE_I && state_q == SDC_ST_DECODE && frame_ok) begin
      if (frame_wr && frame_diag) begin
        mux_q <= frame_q[`SDC_MUX_HI:`SDC_MUX_LO];
      end
    end
  end

  // Readback request is served by the next access and then dropped
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rd_pend_q <= 1'b0;
    end else if (CE_I) begin
      if (state_q == SDC_ST_DECODE && frame_ok) begin
        rd_pend_q <= !frame_wr && frame_diag;
      end else if (state_q == SDC_ST_IDLE && !cs_n_s) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  // Response word, frozen from the start of an access until its end
  // The link reads resp_q untimed, which is safe as it holds still then
  logic [`SDC_FRAME_MSB:0] resp_d;
  logic                    byp_rd;

  always_comb begin
    byp_rd = byp_s && (mux_q != `SDC_MUX_STBY);
    if (rd_pend_q) begin
      resp_d = {1'b0, `SDC_ADDR_DIAG, byp_rd, mux_q};
    end else begin
      resp_d = {1'b0, aux_s, 1'b0, fault_s};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      resp_q <= `SDC_RESP_RST;
    end else if (CE_I && state_q == SDC_ST_IDLE && cs_n_s) begin
      resp_q <= resp_d;
    end
  end

  // Serial output pin and its enable
  // The pre-clock level follows SI through its synchroniser, so a fault
  // flagged upstream in a chain is passed on down it
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      SO_O      <= 1'b0;
      SO_OE_N_O <= 1'b1;
    end else if (CE_I) begin
      if (cs_n_s) begin
        SO_O      <= 1'b0;
        SO_OE_N_O <= 1'b1;
      end else begin
        SO_OE_N_O <= 1'b0;
        if (!rose_s) begin
          SO_O <= ter_q | si_s;
        end else begin
          SO_O <= tx_s;
        end
      end
    end
  end

  // Sense path control: one match term per channel, so codes above the
  // last channel and switched-off channels both leave the path idle
  logic            sense_on;
  logic [2:0]      sense_ch;
  logic [CH_N-1:0] route_hit;

  for (genvar g = 0; g < CH_N; g++) begin : g_route
    assign route_hit[g] = CHANNEL_ON_I[g] &&
                          (mux_q == 3'(g));
  end

  always_comb begin
    sense_ch = mux_q;
    sense_on = 1'b0;
    if (mux_q <= `SDC_MUX_LAST_CH) begin
      sense_on = |route_hit;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      SENSE_EN_O     <= 1'b0;
      SENSE_SELECT_O <= `SDC_MUX_OFF;
      STANDBY_O      <= 1'b0;
      FRAME_ERROR_O  <= 1'b0;
    end else if (CE_I) begin
      SENSE_EN_O     <= sense_on;
      SENSE_SELECT_O <= sense_ch;
      STANDBY_O      <= (mux_q == `SDC_MUX_STBY);
      FRAME_ERROR_O  <= ter_q;
    end
  end

endmodule : sdc_spi_diag_slave

// ==== dv/sdc_spi_diag_slave_assertions.sv ====
// Checker for the diagnosis serial slave, on its top-level ports.
// Assumes one system clock domain and registered outputs.
`timescale 1ns/1ps
module sdc_chk #(
  parameter int CH_N = 5
) (
  // Clock and reset
  input wire logic            CLK_I,
  input wire logic            SYS_RST_I,
  // Serial side
  input wire logic            CS_N_I,
  input wire logic            SO_O,
  input wire logic            SO_OE_N_O,
  // Sense path and status
  input wire logic [CH_N-1:0] CHANNEL_ON_I,
  input wire logic            SENSE_EN_O,
  input wire logic [2:0]      SENSE_SELECT_O,
  input wire logic            STANDBY_O,
  input wire logic            FRAME_ERROR_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  sequence s_open;
    $fell(CS_N_I);
  endsequence
  sequence s_fault;
    $rose(FRAME_ERROR_O);
  endsequence

  AST_OE_ON: assert property (s_open |-> ##[1:6] !SO_OE_N_O)
    else $error("no output after select fell");
  AST_OE_OFF: assert property (CS_N_I [*8] |-> SO_OE_N_O)
    else $error("output driven while deselected");
  AST_PRE_TER: assert property (
    $fell(SO_OE_N_O) && FRAME_ERROR_O |-> SO_O)
    else $error("first bit hides the frame error");
  AST_DECODE_LATE: assert property (
    $changed(SENSE_SELECT_O) |-> CS_N_I && $past(CS_N_I, 3))
    else $error("sense select changed inside an access");
  AST_ERR_AT_END: assert property (s_fault |-> CS_N_I)
    else $error("frame error raised inside an access");
  AST_ERR_KEEP: assert property (
    s_fault |-> $stable(SENSE_SELECT_O) [*4])
    else $error("bad frame changed sense select");
  AST_STBY: assert property (
    STANDBY_O == (SENSE_SELECT_O == 3'h7))
    else $error("standby disagrees with sense select");
  AST_SENSE_EN: assert property (
    SENSE_EN_O && $stable(CHANNEL_ON_I) |->
      SENSE_SELECT_O <= 3'h4 && CHANNEL_ON_I[SENSE_SELECT_O])
    else $error("sense routed for an idle code or off channel");
endmodule : sdc_chk

// ==== dv/sdc_mst.sv ====
// Master model of the serial link: select, serial clock and data.
// Assumes the slave answers within tens of ns of each edge.
`timescale 1ns/1ps
module sdc_mst (
  // Toward the slave
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o,
  // From the slave
  input  wire logic so_i
);
  logic lclk;
  logic pre_bit;

  // Timing base; the serial clock only moves inside accesses
  initial begin
    lclk = 1'b0;
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    forever #6 lclk = ~lclk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge lclk);
  endtask : tick

  task automatic xfer(input int n, input logic [31:0] mo,
                      output logic [31:0] mi);
    mi = '0;
    cs_n_o <= 1'b0;
    si_o <= (n > 0) ? mo[n-1] : 1'b0;
    tick(84);
    pre_bit = so_i;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o <= 1'b1;
      si_o <= mo[i];
      tick(24);
      mi = {mi[30:0], so_i};
      sclk_o <= 1'b0;
      tick(24);
    end
    tick(84);
    cs_n_o <= 1'b1;
    si_o <= 1'b0;
    tick(84);
  endtask : xfer
endmodule : sdc_mst

// ==== dv/tb_top.sv ====
// Bench for the diagnosis serial slave with master model and checker.
// Assumes design, package and checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic        CLK_I, CE_I, SYS_RST_I, SCLK_I, CS_N_I, SI_I, SO_O;
  logic        SO_OE_N_O, AUX_STATUS_I, BYPASS_MONITOR_I, SENSE_EN_O;
  logic        STANDBY_O, FRAME_ERROR_O, so_last, so_w;
  logic [4:0]  CHANNEL_ON_I, CHANNEL_FAULT_I;
  logic [2:0]  SENSE_SELECT_O;
  logic [31:0] rx;
  int          n_fail, checked;

  sdc_spi_diag_slave DUT (.CLK_I, .CE_I, .SYS_RST_I, .SCLK_I, .CS_N_I,
    .SI_I, .SO_O, .SO_OE_N_O, .CHANNEL_ON_I, .CHANNEL_FAULT_I,
    .AUX_STATUS_I, .BYPASS_MONITOR_I, .SENSE_EN_O, .SENSE_SELECT_O,
    .STANDBY_O, .FRAME_ERROR_O);
  sdc_mst M (.sclk_o(SCLK_I), .cs_n_o(CS_N_I), .si_o(SI_I), .so_i(so_w));

  // Released line shows the inverse of its last driven level
  always @(posedge CLK_I) if (!SO_OE_N_O) so_last <= SO_O;
  assign so_w = SO_OE_N_O ? ~so_last : SO_O;

  initial begin
    CLK_I = 1'b0;
    forever #2.5 CLK_I = ~CLK_I;
  end

  task automatic chk(input string nm, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic sense(input logic [2:0] s, input logic en, sb);
    chk("sense_select", {5'h0, s}, {5'h0, SENSE_SELECT_O});
    chk("sense_en", {7'h0, en}, {7'h0, SENSE_EN_O});
    chk("standby", {7'h0, sb}, {7'h0, STANDBY_O});
  endtask : sense

  task automatic frame(input int n, input logic [31:0] mo);
    M.xfer(n, mo, rx);
    repeat (8) @(posedge CLK_I);
  endtask : frame

  task automatic setin(input logic [4:0] on, fl, input logic aux, byp);
    @(posedge CLK_I);
    CHANNEL_ON_I <= on;
    CHANNEL_FAULT_I <= fl;
    AUX_STATUS_I <= aux;
    BYPASS_MONITOR_I <= byp;
    repeat (8) @(posedge CLK_I);
  endtask : setin

  task automatic t_std();
    chk("so_oe_n", 8'h01, {7'h0, SO_OE_N_O});
    chk("frame_error", 8'h00, {7'h0, FRAME_ERROR_O});
    sense(3'h6, 1'b0, 1'b0);
    setin(5'h1f, 5'h15, 1'b1, 1'b0);
    frame(8, 8'h60);
    chk("pre_bit", 8'h00, {7'h0, M.pre_bit});
    chk("std_resp", 8'h55, rx[7:0]);
    setin(5'h1f, 5'h0a, 1'b0, 1'b0);
    frame(8, 8'h60);
    chk("std_resp", 8'h0a, rx[7:0]);
    $display("t_std done");
  endtask : t_std

  task automatic t_sense();
    for (int c = 0; c < 8; c++) begin
      frame(8, 32'hf0 | c);
      sense(c[2:0], c < 5, c == 7);
    end
    setin(5'h1b, 5'h0a, 1'b0, 1'b0);
    frame(8, 8'hf2);
    sense(3'h2, 1'b0, 1'b0);
    frame(8, 8'hf3);
    sense(3'h3, 1'b1, 1'b0);
    $display("t_sense done");
  endtask : t_sense

  task automatic t_readback();
    setin(5'h1f, 5'h00, 1'b0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      frame(8, i ? 8'hf7 : 8'hf5);
      frame(8, 8'h70);
      frame(8, 8'h60);
      chk("readback", i ? 8'h77 : 8'h7d, rx[7:0]);
    end
    frame(8, 8'h60);
    chk("std_resp", 8'h00, rx[7:0]);
    $display("t_readback done");
  endtask : t_readback

  task automatic t_error();
    frame(0, 32'h0);
    chk("frame_error", 8'h01, {7'h0, FRAME_ERROR_O});
    frame(8, 8'h60);
    chk("pre_bit", 8'h01, {7'h0, M.pre_bit});
    chk("frame_error", 8'h00, {7'h0, FRAME_ERROR_O});
    frame(9, 32'h1f4);
    chk("frame_error", 8'h01, {7'h0, FRAME_ERROR_O});
    sense(3'h7, 1'b0, 1'b1);
    frame(16, 32'haaf4);
    chk("chain_resp", 8'h00, rx[15:8]);
    chk("chain_pass", 8'haa, rx[7:0]);
    sense(3'h4, 1'b1, 1'b0);
    $display("t_error done");
  endtask : t_error

  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    n_fail = 0;
    checked = 0;
    so_last = 1'b0;
    CE_I = 1'b1;
    SYS_RST_I = 1'b1;
    CHANNEL_ON_I = 5'h00;
    CHANNEL_FAULT_I = 5'h00;
    AUX_STATUS_I = 1'b0;
    BYPASS_MONITOR_I = 1'b0;
    repeat (16) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    repeat (8) @(posedge CLK_I);
    t_std();
    t_sense();
    t_readback();
    t_error();
    wrap_up();
  end

  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule : tb_top

bind sdc_spi_diag_slave sdc_chk #(.CH_N(CH_N)) CHK (.CLK_I, .SYS_RST_I,
  .CS_N_I, .SO_O, .SO_OE_N_O, .CHANNEL_ON_I, .SENSE_EN_O, .SENSE_SELECT_O,
  .STANDBY_O, .FRAME_ERROR_O);
